// >>> pkg/ctm_pkg.sv
`default_nettype none
package ctm_pkg;
  // clock and bus-silence timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SILENCE_TIME_US = 1000;
  localparam int SILENCE_CYCLES = (SILENCE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // chip operating mode codes
  localparam logic [2:0] MC_OFF = 3'h0;
  localparam logic [2:0] MC_SLEEP = 3'h1;
  localparam logic [2:0] MC_OVERTEMP = 3'h2;
  localparam logic [2:0] MC_RESET = 3'h3;
  localparam logic [2:0] MC_STANDBY = 3'h4;
  localparam logic [2:0] MC_NORMAL = 3'h7;

  // can mode select codes
  localparam logic [1:0] SEL_OFFLINE = 2'h0;
  localparam logic [1:0] SEL_ACT_UV = 2'h1;
  localparam logic [1:0] SEL_ACT_NOUV = 2'h2;
  localparam logic [1:0] SEL_LISTEN = 2'h3;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h08;

  // field positions and reset values
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_CWE_BIT = 2;
  localparam int ST_CTS_BIT = 7;
  localparam int ST_SILENT_BIT = 3;
  localparam int ST_VCS_BIT = 1;
  localparam int ST_MODE_LSB = 8;
  localparam int EV_WAKE_BIT = 0;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic CWE_RST = 1'b0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CTM_OFF,
    CTM_OFFLINE,
    CTM_OFFLINE_BIAS,
    CTM_LISTEN,
    CTM_ACTIVE
  } ctm_state_e;
endpackage
`default_nettype wire

// >>> rtl/ctm_silence_timer.sv
`default_nettype none
module ctm_silence_timer #(
  parameter int LIMIT = 25000
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic bus_edge,
  output logic silent
);
  localparam int CW = $clog2(LIMIT + 1);

  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic silent_r;
  logic silent_nxt;

  generate
    if (LIMIT < 1) begin : g_bad
      $error("silence limit must be at least one cycle");
    end
  endgenerate

  // every bus edge restarts the count; it saturates at the limit
  always_comb begin
    count_nxt = count_r;
    if (bus_edge) begin
      count_nxt = '0;
    end else if (count_r < CW'(LIMIT)) begin
      count_nxt = count_r + CW'(1);
    end
    silent_nxt = (count_nxt >= CW'(LIMIT));
  end

  // start silent-free: the bus counts as active right after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      count_r <= '0;
      silent_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      silent_r <= silent_nxt;
    end
  end

  assign silent = silent_r;

  // silence needs the full count
  silent_count_a: assert property (@(posedge clk) disable iff (srst) silent_r |-> count_r == CW'(LIMIT))
    else $error("silent flag without full count");
endmodule
`default_nettype wire

// >>> rtl/ctm_mode_ctrl.sv
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - mode select honoured only in normal; standby or sleep force offline or bias.
// - select 01 and 10 both request active mode.
// - select 01 drops active when regulator falls below can undervoltage.
// - select 10 ignores undervoltage; chip reset then drops the transceiver.
// - active only in normal, select 01 or 10, matching supply good.
// - transmit input low on active request gives listen until it rises.
// - normal with select 11 gives listen-only: transmitter off, receiver on.
// - listen held while select 01 and regulator below 90 percent.
// - offline grounds bus; wake watched only with wake enable set.
// - bus activity in offline moves to offline bias.
// - offline bias returns to offline after bus-silence timeout.
// - active or listen leave on reset, standby, sleep or select 00.
// - leaving goes offline if silent, else through offline bias.
// - leaving off or overtemp into reset enters offline.
// - wake pattern or normal active select with low can supply gives bias.
// - bus biased mid-level throughout active and listen.
// - readable status bit shows active mode.
// - off or overtemp or battery low switches transceiver fully off.
// - off exits to offline once battery good and chip mode allows.
// - valid wake pattern sets wake flag and drives receive output low.
module ctm_mode_ctrl
  import ctm_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int SILENCE_LIMIT = SILENCE_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] chip_mode_field,
  input wire logic txd,
  input wire logic bus_rx,
  input wire logic bat_low,
  input wire logic main_regulator_output_low,
  input wire logic main_regulator_output_reset,
  input wire logic can_supply_voltage_low,
  input wire logic wake_pattern,
  output logic rxd,
  output logic tx_enable,
  output logic bias_mid,
  output logic bias_gnd,
  output logic can_off
);
  generate
    if (ADDR_W < 4 || ADDR_W > 8) begin : g_bad
      $error("ADDR_W must lie between 4 and 8");
    end
  endgenerate

  // register word select, shared by read and write decode
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
    reg_hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops before any logic looks at a pin
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_in;
  logic [NPIN-1:0] sync2_r;
  logic [1:0] dly_r;

  assign pin_in = {wake_pattern, can_supply_voltage_low, main_regulator_output_reset,
                   main_regulator_output_low, bat_low, bus_rx, txd};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      // each pin keeps its own pair of flops, so no vector has several writers
      logic s1_r;
      logic s2_r;
      always_ff @(posedge clk) begin
        if (srst) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
        end else begin
          s1_r <= pin_in[gi];
          s2_r <= s1_r;
        end
      end
      assign sync2_r[gi] = s2_r;
    end
  endgenerate

  // one more stage for edge detection on bus and wake lines
  always_ff @(posedge clk) begin
    if (srst) begin
      dly_r <= 2'h3;
    end else begin
      dly_r <= {sync2_r[6], sync2_r[1]};
    end
  end

  logic txd_s, bus_s, bat_low_s, mreg_low_s, mreg_rst_s, can_supply_voltage_low_s, wake_s;
  assign {wake_s, can_supply_voltage_low_s, mreg_rst_s, mreg_low_s, bat_low_s, bus_s, txd_s} = sync2_r;

  //////////////////////////////////////////////////////////////////////////////
  // decoded conditions
  logic [1:0] sel_r;
  logic cwe_r;
  logic wake_flag_r;
  ctm_state_e state_r;
  ctm_state_e state_nxt;
  logic silent;
  logic bus_edge;
  logic wake_hit;
  logic normal;
  logic act_sel;
  logic act_ok;
  logic listen_req;
  logic hold_listen;
  logic uv_bias;
  logic force_off;

  assign bus_edge = bus_s ^ dly_r[0];
  assign normal = (chip_mode_field == MC_NORMAL);
  assign act_sel = (sel_r == SEL_ACT_UV) || (sel_r == SEL_ACT_NOUV);
  assign act_ok = normal && act_sel && ((sel_r == SEL_ACT_UV) ? !mreg_low_s : !mreg_rst_s);
  assign listen_req = normal && (sel_r == SEL_LISTEN);
  // listen kept under 90 percent with select 01
  assign hold_listen = (state_r == CTM_LISTEN) && normal && (sel_r == SEL_ACT_UV) && mreg_low_s;
  // low can supply while active requested
  assign uv_bias = normal && act_sel && can_supply_voltage_low_s;
  assign force_off = bat_low_s || (chip_mode_field == MC_OFF) || (chip_mode_field == MC_OVERTEMP);
  // wake only seen in offline with wake enable
  assign wake_hit = (state_r == CTM_OFFLINE) && cwe_r && wake_s && !dly_r[1];

  ctm_silence_timer #(
    .LIMIT(SILENCE_LIMIT)
  ) u_silence (
    .clk(clk),
    .srst(srst),
    .bus_edge(bus_edge),
    .silent(silent)
  );

  //////////////////////////////////////////////////////////////////////////////
  // transceiver mode state machine; txd only gates entry, so dominant bits
  // sent while active never push the transceiver back to listen
  always_comb begin
    state_nxt = state_r;
    if (force_off) begin
      state_nxt = CTM_OFF;
    end else begin
      case (state_r)
        CTM_OFF: begin
          state_nxt = CTM_OFFLINE;
        end
        CTM_ACTIVE, CTM_LISTEN: begin
          if (act_ok) begin
            state_nxt = (state_r == CTM_ACTIVE || txd_s) ? CTM_ACTIVE : CTM_LISTEN;
          end else if (listen_req || hold_listen) begin
            state_nxt = CTM_LISTEN;
          end else begin
            state_nxt = silent ? CTM_OFFLINE : CTM_OFFLINE_BIAS;
          end
        end
        CTM_OFFLINE: begin
          if (act_ok) begin
            state_nxt = txd_s ? CTM_ACTIVE : CTM_LISTEN;
          end else if (listen_req) begin
            state_nxt = CTM_LISTEN;
          end else if (wake_hit || bus_edge || uv_bias) begin
            state_nxt = CTM_OFFLINE_BIAS;
          end
        end
        CTM_OFFLINE_BIAS: begin
          if (act_ok) begin
            state_nxt = txd_s ? CTM_ACTIVE : CTM_LISTEN;
          end else if (listen_req) begin
            state_nxt = CTM_LISTEN;
          // silence returns to offline; held while a low supply would pull it straight back
          end else if (silent && !uv_bias) begin
            state_nxt = CTM_OFFLINE;
          end
        end
        default: begin
          state_nxt = CTM_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= CTM_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin outputs, registered from the next state so they line up with state_r
  logic rxd_r, tx_en_r, bias_mid_r, bias_gnd_r, off_r, cts_r;
  logic rxd_nxt, tx_en_nxt, bias_mid_nxt, bias_gnd_nxt, off_nxt, cts_nxt;
  logic wake_flag_nxt;

  always_comb begin
    // mid-level bias in active, listen and offline bias
    bias_mid_nxt = (state_nxt == CTM_ACTIVE) || (state_nxt == CTM_LISTEN) || (state_nxt == CTM_OFFLINE_BIAS);
    bias_gnd_nxt = (state_nxt == CTM_OFFLINE);
    tx_en_nxt = (state_nxt == CTM_ACTIVE);
    off_nxt = (state_nxt == CTM_OFF);
    cts_nxt = (state_nxt == CTM_ACTIVE);
    // outside active and listen, receive output pulled low while the wake flag stands
    if ((state_nxt == CTM_ACTIVE) || (state_nxt == CTM_LISTEN)) begin
      rxd_nxt = bus_s;
    end else begin
      rxd_nxt = !wake_flag_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rxd_r <= 1'b1;
      tx_en_r <= 1'b0;
      bias_mid_r <= 1'b0;
      bias_gnd_r <= 1'b0;
      off_r <= 1'b1;
      cts_r <= 1'b0;
    end else begin
      rxd_r <= rxd_nxt;
      tx_en_r <= tx_en_nxt;
      bias_mid_r <= bias_mid_nxt;
      bias_gnd_r <= bias_gnd_nxt;
      off_r <= off_nxt;
      cts_r <= cts_nxt;
    end
  end

  assign rxd = rxd_r;
  assign tx_enable = tx_en_r;
  assign bias_mid = bias_mid_r;
  assign bias_gnd = bias_gnd_r;
  assign can_off = off_r;

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: one write and one read in flight, read answered one cycle later, write two cycles later
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
  logic have_aw_r, have_w_r, have_aw_nxt, have_w_nxt;
  logic [ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt, sel_nxt;
  logic cwe_nxt;
  logic do_write;
  logic wake_clr;

  always_comb begin
    have_aw_nxt = have_aw_r || (s_axi_awvalid && awready_r);
    have_w_nxt = have_w_r || (s_axi_wvalid && wready_r);
    waddr_nxt = (s_axi_awvalid && awready_r) ? s_axi_awaddr : waddr_r;
    wdata_nxt = (s_axi_wvalid && wready_r) ? s_axi_wdata : wdata_r;
    wstrb_nxt = (s_axi_wvalid && wready_r) ? s_axi_wstrb : wstrb_r;
    do_write = have_aw_r && have_w_r && !bvalid_r;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    sel_nxt = sel_r;
    cwe_nxt = cwe_r;
    wake_clr = 1'b0;
    if (do_write) begin
      have_aw_nxt = 1'b0;
      have_w_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (reg_hit(waddr_r, OFS_CTRL)) begin
        if (wstrb_r[0]) begin
          sel_nxt = wdata_r[CTRL_SEL_LSB +: 2];
          cwe_nxt = wdata_r[CTRL_CWE_BIT];
        end
      end else if (reg_hit(waddr_r, OFS_EVENT)) begin
        wake_clr = wstrb_r[0] && wdata_r[EV_WAKE_BIT];
      end else if (!reg_hit(waddr_r, OFS_STATUS)) begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    awready_nxt = !have_aw_nxt;
    wready_nxt = !have_w_nxt;
    // set wins over a clear in the same cycle
    wake_flag_nxt = (wake_flag_r && !wake_clr) || wake_hit;
    // read channel
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = '0;
      rresp_nxt = RESP_OKAY;
      if (reg_hit(s_axi_araddr, OFS_CTRL)) begin
        rdata_nxt[CTRL_SEL_LSB +: 2] = sel_r;
        rdata_nxt[CTRL_CWE_BIT] = cwe_r;
      end else if (reg_hit(s_axi_araddr, OFS_STATUS)) begin
        rdata_nxt[ST_CTS_BIT] = cts_r;
        rdata_nxt[ST_SILENT_BIT] = silent;
        rdata_nxt[ST_VCS_BIT] = can_supply_voltage_low_s;
        rdata_nxt[ST_MODE_LSB +: 3] = state_r;
      end else if (reg_hit(s_axi_araddr, OFS_EVENT)) begin
        rdata_nxt[EV_WAKE_BIT] = wake_flag_r;
      end else begin
        rresp_nxt = RESP_SLVERR;
      end
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      have_aw_r <= 1'b0;
      have_w_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      rdata_r <= 32'h0000_0000;
      bresp_r <= RESP_OKAY;
      rresp_r <= RESP_OKAY;
      sel_r <= SEL_RST;
      cwe_r <= CWE_RST;
      wake_flag_r <= 1'b0;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      have_aw_r <= have_aw_nxt;
      have_w_r <= have_w_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      rdata_r <= rdata_nxt;
      bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;
      sel_r <= sel_nxt;
      cwe_r <= cwe_nxt;
      wake_flag_r <= wake_flag_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks on the mode machine
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  active_entry_a: assert property (state_r == CTM_ACTIVE |-> $past(act_ok))
    else $error("active mode without a valid request");
  listen_txd_a: assert property (state_r == CTM_LISTEN && act_ok && !txd_s && !force_off |=> state_r == CTM_LISTEN)
    else $error("left listen while txd low");
  select_listen_a: assert property (listen_req && !force_off && state_r != CTM_OFF |=> state_r == CTM_LISTEN)
    else $error("select 11 did not give listen");
  uv_drop_a: assert property (state_r == CTM_ACTIVE && !act_ok && !listen_req && !force_off |=> state_r != CTM_ACTIVE)
    else $error("active kept after supply loss");
  bias_mid_a: assert property (state_r == CTM_ACTIVE || state_r == CTM_LISTEN |-> bias_mid_r && !bias_gnd_r)
    else $error("bus not biased in active or listen");
  cts_state_a: assert property (cts_r == (state_r == CTM_ACTIVE))
    else $error("status bit disagrees with mode");
  silence_exit_a: assert property (state_r == CTM_OFFLINE_BIAS && silent && !act_ok && !listen_req && !force_off
                                   && !uv_bias |=> state_r == CTM_OFFLINE)
    else $error("bias kept after silence");
  leave_bias_a: assert property ((state_r == CTM_ACTIVE || state_r == CTM_LISTEN) && !act_ok && !listen_req
                                 && !hold_listen && !silent && !force_off |=> state_r == CTM_OFFLINE_BIAS)
    else $error("left without passing offline bias");
  offline_act_a: assert property (state_r == CTM_OFFLINE && bus_edge && !act_ok && !listen_req && !force_off
                                  |=> state_r == CTM_OFFLINE_BIAS && bias_mid_r)
    else $error("activity in offline ignored");
  full_off_a: assert property (force_off |=> state_r == CTM_OFF && can_off && !bias_mid_r && !bias_gnd_r)
    else $error("transceiver not switched off");
  wake_flag_a: assert property (wake_hit |=> wake_flag_r && !rxd_r)
    else $error("wake pattern not flagged");
endmodule
`default_nettype wire

// >>> verif/ctm_can_node.sv
`default_nettype none
// far-side node: protocol controller txd pin and a bus that can show a burst of edges
module ctm_can_node (
  input wire logic clk,
  input wire logic srst,
  input wire logic hold_txd_low,
  input wire logic burst,
  output logic txd,
  output var logic bus_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  int left;
  // a stuck-low txd mimics a controller pin shorted to ground
  assign txd = !hold_txd_low;
  // recessive when idle; a burst toggles every clock so each cycle carries an edge
  always @(posedge clk) begin
    if (srst) begin
      left <= 0;
      bus_rx <= 1'b1;
    end else if (burst) begin
      left <= 16;
    end else if (left > 0) begin
      left <= left - 1;
      bus_rx <= !bus_rx;
    end else begin
      bus_rx <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb_can_transceiver_mode_control.sv
`default_nettype none
module tb_can_transceiver_mode_control import ctm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp;
  logic [2:0] mode;
  logic txd, bus_rx, bat_low, reg_low, reg_rst, sup_low, wake, rxd, tx_enable, bias_mid, bias_gnd, can_off;
  logic hold_low, burst;
  int fails, checks;

  ctm_mode_ctrl #(.SILENCE_LIMIT(20)) ctm_mode_ctrl_i (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .chip_mode_field(mode), .txd(txd), .bus_rx(bus_rx), .bat_low(bat_low), .main_regulator_output_low(reg_low),
    .main_regulator_output_reset(reg_rst), .can_supply_voltage_low(sup_low), .wake_pattern(wake), .rxd(rxd),
    .tx_enable(tx_enable), .bias_mid(bias_mid), .bias_gnd(bias_gnd), .can_off(can_off));
  ctm_can_node ctm_can_node_i (.clk(clk), .srst(srst), .hold_txd_low(hold_low), .burst(burst), .txd(txd),
    .bus_rx(bus_rx));

  //////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end

  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pin(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  // a hung handshake counts as a mismatch and ends the run
  task automatic guard(input int n);
    if (n > 40) begin
      fails++;
      $display("CHECK FAILED handshake expected answer seen none");
      complete_run();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite master: each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        got = 1'b1;
        bready <= 1'b0;
        chk_word("bresp", {30'h0, er}, {30'h0, bresp});
      end
      guard(n);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        got = 1'b1;
        v = rdata;
        rready <= 1'b0;
        chk_word("rresp", {30'h0, er}, {30'h0, rresp});
      end
      guard(n);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic pulse_burst();
    @(posedge clk);
    burst <= 1'b1;
    @(posedge clk);
    burst <= 1'b0;
  endtask

  // status state field plus the bias and driver pins expected in that state
  task automatic cst(input logic [2:0] s);
    logic [31:0] v;
    wt(6);
    rd(OFS_STATUS, v, RESP_OKAY);
    chk_word("state", {29'h0, s}, {29'h0, v[ST_MODE_LSB +: 3]});
    chk_pin("active_bit", s == CTM_ACTIVE, v[ST_CTS_BIT]);
    chk_pin("tx_enable", s == CTM_ACTIVE, tx_enable);
    chk_pin("bias_mid", s >= CTM_OFFLINE_BIAS, bias_mid);
    chk_pin("bias_gnd", s == CTM_OFFLINE, bias_gnd);
    chk_pin("can_off", s == CTM_OFF, can_off);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {bat_low, reg_low, reg_rst, sup_low, wake, hold_low, burst} = '0;
    fails = 0;
    checks = 0;
    mode = MC_RESET;
    srst = 1'b1;
    wt(4);
    srst <= 1'b0;
    wt(40);
    cst(CTM_OFFLINE);
    rd(OFS_CTRL, d, RESP_OKAY);
    chk_word("ctrl", 32'h0, d);
    rd(OFS_STATUS, d, RESP_OKAY);
    chk_pin("silent", 1'b1, d[ST_SILENT_BIT]);
    wr(8'h0C, 32'h1, RESP_SLVERR);
    rd(8'h0C, d, RESP_SLVERR);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    cst(CTM_OFFLINE);
    mode <= MC_NORMAL;
    cst(CTM_ACTIVE);
    chk_pin("rxd", bus_rx, rxd);
    reg_low <= 1'b1;
    cst(CTM_OFFLINE);
    reg_low <= 1'b0;
    cst(CTM_ACTIVE);
    wr(OFS_CTRL, 32'h2, RESP_OKAY);
    reg_low <= 1'b1;
    cst(CTM_ACTIVE);
    reg_rst <= 1'b1;
    cst(CTM_OFFLINE);
    reg_rst <= 1'b0;
    reg_low <= 1'b0;
    cst(CTM_ACTIVE);
    pulse_burst();
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    cst(CTM_OFFLINE_BIAS);
    wt(40);
    cst(CTM_OFFLINE);
    pulse_burst();
    cst(CTM_OFFLINE_BIAS);
    wt(40);
    hold_low <= 1'b1;
    wr(OFS_CTRL, 32'h2, RESP_OKAY);
    cst(CTM_LISTEN);
    hold_low <= 1'b0;
    cst(CTM_ACTIVE);
    wr(OFS_CTRL, 32'h3, RESP_OKAY);
    cst(CTM_LISTEN);
    reg_low <= 1'b1;
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    cst(CTM_LISTEN);
    reg_low <= 1'b0;
    cst(CTM_ACTIVE);
    mode <= MC_STANDBY;
    cst(CTM_OFFLINE);
    wr(OFS_CTRL, 32'h3, RESP_OKAY);
    cst(CTM_OFFLINE);
    mode <= MC_NORMAL;
    cst(CTM_LISTEN);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    cst(CTM_OFFLINE);
    reg_low <= 1'b1;
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    cst(CTM_OFFLINE);
    sup_low <= 1'b1;
    cst(CTM_OFFLINE_BIAS);
    rd(OFS_STATUS, d, RESP_OKAY);
    chk_pin("supply_low", 1'b1, d[ST_VCS_BIT]);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    {reg_low, sup_low} <= 2'b00;
    wt(40);
    // wake watched only with the enable bit set
    wr(OFS_CTRL, 32'h4, RESP_OKAY);
    wake <= 1'b1;
    wt(3);
    wake <= 1'b0;
    wt(6);
    rd(OFS_EVENT, d, RESP_OKAY);
    chk_word("wake_flag", 32'h1, d);
    chk_pin("rxd", 1'b0, rxd);
    // active passes the bus level even while the wake flag stands
    wr(OFS_CTRL, 32'h5, RESP_OKAY);
    cst(CTM_ACTIVE);
    chk_pin("rxd", 1'b1, rxd);
    wr(OFS_CTRL, 32'h4, RESP_OKAY);
    cst(CTM_OFFLINE);
    chk_pin("rxd", 1'b0, rxd);
    wr(OFS_EVENT, 32'h1, RESP_OKAY);
    rd(OFS_EVENT, d, RESP_OKAY);
    chk_word("wake_flag", 32'h0, d);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    wt(40);
    chk_pin("rxd", 1'b1, rxd);
    wake <= 1'b1;
    wt(3);
    wake <= 1'b0;
    wt(6);
    rd(OFS_EVENT, d, RESP_OKAY);
    chk_word("wake_flag", 32'h0, d);
    mode <= MC_OFF;
    cst(CTM_OFF);
    mode <= MC_RESET;
    cst(CTM_OFFLINE);
    bat_low <= 1'b1;
    cst(CTM_OFF);
    bat_low <= 1'b0;
    cst(CTM_OFFLINE);
    complete_run();
  end
endmodule
`default_nettype wire
